// ---- pkg/ptmc_pkg.sv ----
// constants, field layout and modes of the periodic timer mode control block
// Contract
// - mode field 00 compare output, 01 capture, 10 pwm/single pulse, 11 timer
// - timer/counter mode leaves output pin undefined; pin function unused there
// - compare mode on match A: 00 hold, 01 low, 10 high, 11 toggle
// - pwm mode pin function: 00 inactive, 01 active, 10 pwm, 11 single pulse
// - capture mode: 00 rising, 01 falling, 10 both edges, 11 disabled
// - compare mode match requesting the current level causes no visible change
// - compare mode output returns to initial level on timer_on rising edge
// - compare mode output_control sets initial level, 0 low, 1 high
// - pwm mode output_control selects active level, 0 low, 1 high
// - single pulse output_control sets pin level at timer_on rising edge
// - output_invert inverts pin; neither bit affects timer/counter mode
// - capture source 0 dedicated capture pin, 1 external clock pin
// - clear_select 1 clears counter on comparator A match
// - clear_select 0 clears counter on comparator P match or overflow
// - overflow clearing only when period compare value is all zero
// - clear_select ignored in pwm, single pulse and capture modes
// - ten-bit up counter, both comparators compare all bits
// - timer_on rise zeroes counter; fall stops counter keeping its value
package ptmc_pkg;
  localparam int CNT_W = 10;
  localparam int ADDR_W = 4;
  // register indices (byte addresses of an 8-bit register file)
  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_CNT_L = 4'h2;
  localparam logic [3:0] ADDR_CNT_H = 4'h3;
  localparam logic [3:0] ADDR_CMPA_L = 4'h4;
  localparam logic [3:0] ADDR_CMPA_H = 4'h5;
  localparam logic [3:0] ADDR_PER_L = 4'h6;
  localparam logic [3:0] ADDR_PER_H = 4'h7;
  // control 0 fields
  localparam int BIT_ON = 3;
  // control 1 fields
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_PF_HI = 5;
  localparam int BIT_PF_LO = 4;
  localparam int BIT_OC = 3;
  localparam int BIT_INV = 2;
  localparam int BIT_CAPS = 1;
  localparam int BIT_CCLR = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL0_MASK = 8'h08;
  localparam logic [1:0] HI_MASK = 2'h3;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } ptmc_mode_e;
  localparam logic [1:0] PF_00 = 2'b00;
  localparam logic [1:0] PF_01 = 2'b01;
  localparam logic [1:0] PF_10 = 2'b10;
  localparam logic [1:0] PF_11 = 2'b11;
endpackage

// ---- hdl/ptmc_timer.sv ----
// periodic timer core with mode control register decoding
`timescale 1ns/1ps
module ptmc_timer #(
  parameter int CNT_W = ptmc_pkg::CNT_W
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata_ff,
  // timer pins
  input  wire logic              capture_in_pin,
  input  wire logic              ext_clock_pin,
  output logic                   timer_out_pin_ff,
  output logic                   timer_out_oe_ff,
  // events
  output logic                   match_a_ff,
  output logic                   match_p_ff,
  output logic                   capture_ff
);

  logic [7:0]       ctrl0_ff;
  logic [7:0]       ctrl1_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cmpa_ff;
  logic [CNT_W-1:0] per_ff;
  logic             on_d_ff;
  logic             cap_d_ff;
  logic             lvl_ff;
  logic             pulse_done_ff;

  // control field decode
  wire logic [1:0] mode_sel = {ctrl1_ff[ptmc_pkg::BIT_MODE_HI], ctrl1_ff[ptmc_pkg::BIT_MODE_LO]};
  wire logic [1:0] pin_func = {ctrl1_ff[ptmc_pkg::BIT_PF_HI], ctrl1_ff[ptmc_pkg::BIT_PF_LO]};
  wire logic output_control     = ctrl1_ff[ptmc_pkg::BIT_OC];
  wire logic output_invert      = ctrl1_ff[ptmc_pkg::BIT_INV];
  wire logic capture_source_sel = ctrl1_ff[ptmc_pkg::BIT_CAPS];
  wire logic clear_select       = ctrl1_ff[ptmc_pkg::BIT_CCLR];
  wire logic timer_on           = ctrl0_ff[ptmc_pkg::BIT_ON];
  wire logic is_cmp = (mode_sel == ptmc_pkg::MODE_COMPARE);
  wire logic is_cap = (mode_sel == ptmc_pkg::MODE_CAPTURE);
  wire logic is_pwm = (mode_sel == ptmc_pkg::MODE_PWM);
  wire logic is_tmr = (mode_sel == ptmc_pkg::MODE_TIMER);
  wire logic on_rise = timer_on & ~on_d_ff;
  wire logic run     = timer_on & ~on_rise;

  // comparators over every counter bit
  wire logic hit_a   = run & (cnt_ff == cmpa_ff);
  wire logic hit_p   = run & (cnt_ff == per_ff);
  wire logic per_zero = (per_ff == '0);
  wire logic at_max  = (cnt_ff == {CNT_W{1'b1}});
  // clear select only matters in compare and timer modes
  wire logic cmp_like = is_cmp | is_tmr;
  wire logic clr_a   = cmp_like & clear_select & hit_a;
  wire logic clr_p   = ~(cmp_like & clear_select) & hit_p & ~per_zero;
  wire logic clr_ovf = run & at_max & ~(cmp_like & clear_select) & per_zero;
  wire logic cnt_clr = clr_a | clr_p | clr_ovf;
  wire logic [CNT_W-1:0] nxt_cnt = on_rise ? '0 : (!timer_on ? cnt_ff :
                                   (cnt_clr ? '0 : cnt_ff + 1'b1));

  // capture edge detection on selected source
  wire logic cap_src  = capture_source_sel ? ext_clock_pin : capture_in_pin;
  wire logic cap_rise = cap_src & ~cap_d_ff;
  wire logic cap_fall = ~cap_src & cap_d_ff;
  logic cap_edge;
  always_comb begin
    case (pin_func)
      ptmc_pkg::PF_00: cap_edge = cap_rise;
      ptmc_pkg::PF_01: cap_edge = cap_fall;
      ptmc_pkg::PF_10: cap_edge = cap_rise | cap_fall;
      default:         cap_edge = 1'b0;
    endcase
  end
  wire logic do_cap = is_cap & run & cap_edge;

  // internal output level, before polarity
  logic nxt_lvl;
  always_comb begin
    nxt_lvl = lvl_ff;
    if (on_rise) begin
      nxt_lvl = output_control;
    end else if (is_cmp && hit_a) begin
      case (pin_func)
        ptmc_pkg::PF_00: nxt_lvl = lvl_ff;
        ptmc_pkg::PF_01: nxt_lvl = 1'b0;
        ptmc_pkg::PF_10: nxt_lvl = 1'b1;
        default:         nxt_lvl = ~lvl_ff;
      endcase
    end
  end

  // pwm and single pulse waveform, active level from output_control
  wire logic pwm_act = run ? ((cnt_ff < cmpa_ff) | (per_zero ? 1'b0 : (cmpa_ff >= per_ff)))
                           : 1'b0;
  wire logic sp_act  = timer_on & ~pulse_done_ff;
  logic pwm_raw;
  always_comb begin
    case (pin_func)
      ptmc_pkg::PF_00: pwm_raw = ~output_control;
      ptmc_pkg::PF_01: pwm_raw = output_control;
      ptmc_pkg::PF_10: pwm_raw = pwm_act ? output_control : ~output_control;
      default:         pwm_raw = sp_act ? output_control : ~output_control;
    endcase
  end
  wire logic pre_pol = is_pwm ? pwm_raw : lvl_ff;
  wire logic nxt_pin = is_tmr ? 1'b0 : (pre_pol ^ output_invert);
  wire logic nxt_oe  = ~is_tmr & ~is_cap;

  // read mux
  logic [7:0] nxt_rdata;
  always_comb begin
    case (reg_addr)
      ptmc_pkg::ADDR_CTRL0:  nxt_rdata = ctrl0_ff;
      ptmc_pkg::ADDR_CTRL1:  nxt_rdata = ctrl1_ff;
      ptmc_pkg::ADDR_CNT_L:  nxt_rdata = cnt_ff[7:0];
      ptmc_pkg::ADDR_CNT_H:  nxt_rdata = {6'h00, cnt_ff[CNT_W-1:8]};
      ptmc_pkg::ADDR_CMPA_L: nxt_rdata = cmpa_ff[7:0];
      ptmc_pkg::ADDR_CMPA_H: nxt_rdata = {6'h00, cmpa_ff[CNT_W-1:8]};
      ptmc_pkg::ADDR_PER_L:  nxt_rdata = per_ff[7:0];
      ptmc_pkg::ADDR_PER_H:  nxt_rdata = {6'h00, per_ff[CNT_W-1:8]};
      default:               nxt_rdata = 8'h00;
    endcase
  end

  // register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_ff <= ptmc_pkg::CTRL_RST;
      ctrl1_ff <= ptmc_pkg::CTRL_RST;
      per_ff   <= '0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == ptmc_pkg::ADDR_CTRL0) ctrl0_ff <= reg_wdata & ptmc_pkg::CTRL0_MASK;
      if (reg_addr == ptmc_pkg::ADDR_CTRL1) ctrl1_ff <= reg_wdata;
      if (reg_addr == ptmc_pkg::ADDR_PER_L) per_ff[7:0] <= reg_wdata;
      if (reg_addr == ptmc_pkg::ADDR_PER_H) per_ff[CNT_W-1:8] <= reg_wdata[1:0] & ptmc_pkg::HI_MASK;
    end
  end

  // compare A register, loaded by software or by a capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmpa_ff <= '0;
    end else if (clk_en) begin
      if (do_cap) cmpa_ff <= cnt_ff;
      else if (reg_wr && reg_addr == ptmc_pkg::ADDR_CMPA_L) cmpa_ff[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == ptmc_pkg::ADDR_CMPA_H) cmpa_ff[CNT_W-1:8] <= reg_wdata[1:0];
    end
  end

  // counter, edge history and pin state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff           <= '0;
      on_d_ff          <= 1'b0;
      cap_d_ff         <= 1'b0;
      lvl_ff           <= 1'b0;
      pulse_done_ff    <= 1'b0;
      timer_out_pin_ff <= 1'b0;
      timer_out_oe_ff  <= 1'b0;
      match_a_ff       <= 1'b0;
      match_p_ff       <= 1'b0;
      capture_ff       <= 1'b0;
      reg_rdata_ff     <= 8'h00;
    end else if (clk_en) begin
      cnt_ff           <= nxt_cnt;
      on_d_ff          <= timer_on;
      cap_d_ff         <= cap_src;
      lvl_ff           <= nxt_lvl;
      pulse_done_ff    <= on_rise ? 1'b0 : (pulse_done_ff | hit_a);
      timer_out_pin_ff <= nxt_pin;
      timer_out_oe_ff  <= nxt_oe;
      match_a_ff       <= hit_a & ~is_cap;
      match_p_ff       <= hit_p & ~(cmp_like & clear_select);
      capture_ff       <= do_cap;
      reg_rdata_ff     <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  // checks on counter and pin behaviour
  chk_on_rise_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && on_rise |=> cnt_ff == '0) else $error("counter not cleared at enable");
  chk_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !timer_on && !on_d_ff |=> $stable(cnt_ff)) else $error("stopped counter moved");
  chk_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && is_cmp && clear_select && hit_a && !reg_wr |=> cnt_ff == '0)
    else $error("match A did not clear");
  chk_clear_p: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !clear_select && hit_p && !per_zero && !reg_wr |=> cnt_ff == '0)
    else $error("match P did not clear");
  chk_cmp_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && is_cmp && hit_a && !on_rise && pin_func == ptmc_pkg::PF_01 && !reg_wr
    |=> ##1 timer_out_pin_ff == $past(output_invert, 2)) else $error("compare low wrong");
  chk_init_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && is_cmp && on_rise && !reg_wr
    |=> ##1 timer_out_pin_ff == $past(output_control ^ output_invert, 2))
    else $error("initial level wrong");
  chk_capture_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && do_cap |=> capture_ff && cmpa_ff == $past(cnt_ff)) else $error("capture lost");
  chk_timer_no_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && is_tmr && !reg_wr |=> !timer_out_oe_ff) else $error("timer mode drives pin");

endmodule

// ---- sim/ptmc_pins.sv ----
// far-side pin model driving the capture and external clock inputs
`timescale 1ns/1ps
module ptmc_pins (
  // clock
  input  wire logic clk_sys,
  // pulse request from the bench
  input  wire logic go,
  input  wire logic src,
  // pins toward the timer, both idle low
  output logic      capture_in_pin,
  output logic      ext_clock_pin
);
  logic [2:0] hold_ff = 3'h0;
  // one pulse four cycles wide, long enough not to be filtered out
  always @(posedge clk_sys) begin
    if (go) begin
      hold_ff <= 3'h4;
    end else if (hold_ff != 3'h0) begin
      hold_ff <= hold_ff - 3'h1;
    end
  end
  assign capture_in_pin = (hold_ff != 3'h0) && !src;
  assign ext_clock_pin  = (hold_ff != 3'h0) && src;
endmodule

// ---- sim/testbench.sv ----
// self-checking bench for the periodic timer mode control block
`timescale 1ns/1ps
module testbench;
  logic        clk_sys   = 1'b0;
  logic        rst_n     = 1'b0;
  logic        clk_en    = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_d      = 1'b0;
  logic        go        = 1'b0;
  logic        src       = 1'b0;
  logic [31:0] seed      = 32'hd868;
  logic [7:0]  rdata;
  logic        cap_pin, ext_pin, pin, oe, ma, mp, cap;
  logic [7:0]  exp_q[$];
  int          n_fail      = 0;
  int          check_count = 0;
  int          n;
  // clock and parts
  always #10 clk_sys = ~clk_sys;
  ptmc_timer dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .capture_in_pin(cap_pin), .ext_clock_pin(ext_pin), .timer_out_pin_ff(pin),
    .timer_out_oe_ff(oe), .match_a_ff(ma), .match_p_ff(mp), .capture_ff(cap));
  ptmc_pins pins (.clk_sys(clk_sys), .go(go), .src(src), .capture_in_pin(cap_pin),
    .ext_clock_pin(ext_pin));
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // read monitor: data stands only in the cycle after the strobe
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_d) begin
      chk("rdata", {2'b00, rdata}, {2'b00, exp_q.pop_front()});
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected pin level before and after the first comparator A match
  function automatic logic lvl(input int m, input int i, input bit after);
    logic       oc;
    logic [1:0] pf;
    oc = i[2];
    pf = i[1:0];
    if (m == 0) begin
      lvl = !after ? oc : pf == 2'b00 ? oc : pf == 2'b11 ? !oc : pf[1];
    end else begin
      lvl = (after ? pf == 2'b01 : pf != 2'b00) ? oc : !oc;
    end
    return lvl ^ i[3];
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic start(input logic [7:0] c1);
    wr(ptmc_pkg::ADDR_CTRL0, 8'h00);
    wr(ptmc_pkg::ADDR_CTRL1, c1);
    wr(ptmc_pkg::ADDR_CTRL0, 8'h08);
  endtask
  task automatic count(input int which, input int cycles);
    n = 0;
    repeat (cycles) begin
      @(negedge clk_sys);
      if ((which == 0 ? ma : which == 1 ? mp : cap) === 1'b1) n++;
    end
  endtask
  task automatic wait_a();
    int i;
    i = 0;
    while (ma !== 1'b1 && i < 200) begin
      @(negedge clk_sys);
      i++;
    end
    if (i >= 200) begin
      n_fail++;
      close_out();
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    wr(4'h8, 8'hff);
    for (int a = 0; a < 9; a++) rd(a[3:0], 8'h00);
    seed = xs(seed);
    wr(ptmc_pkg::ADDR_CTRL1, seed[7:0]);
    rd(ptmc_pkg::ADDR_CTRL1, seed[7:0]);
    wr(ptmc_pkg::ADDR_CMPA_H, seed[15:8]);
    rd(ptmc_pkg::ADDR_CMPA_H, seed[15:8] & 8'h03);
    wr(ptmc_pkg::ADDR_CTRL0, 8'hff);
    rd(ptmc_pkg::ADDR_CTRL0, 8'h08);
    wr(ptmc_pkg::ADDR_CMPA_H, 8'h00);
    wr(ptmc_pkg::ADDR_CMPA_L, 8'h08);
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 16; i++) begin
        start({m[0], 1'b0, i[1:0], i[2], i[3], 2'b01});
        repeat (3) @(negedge clk_sys);
        chk("oe", oe, 1'b1);
        chk("pin before", pin, lvl(m, i, 0));
        wait_a();
        repeat (2) @(negedge clk_sys);
        chk("pin after", pin, lvl(m, i, 1));
      end
    end
    start(8'h01);
    count(0, 29);
    chk("match a", n, 3);
    count(1, 27);
    chk("match p", n, 0);
    wr(ptmc_pkg::ADDR_PER_L, 8'h0c);
    for (int k = 0; k < 2; k++) begin
      start(k == 0 ? 8'hc0 : 8'h81);
      count(1, 41);
      chk("match p", n, 3);
      chk("oe", oe, k[0]);
    end
    wr(ptmc_pkg::ADDR_PER_L, 8'h00);
    start(8'hc0);
    count(0, 2048);
    chk("match a", n, 2);
    for (int i = 0; i < 8; i++) begin
      start({2'b01, i[1:0], 2'b00, i[2], 1'b0});
      src <= i[2];
      go  <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      count(2, 20);
      chk("captures", n, i[1] ? (i[0] ? 0 : 2) : 1);
      chk("oe", oe, 1'b0);
    end
    repeat (4) @(posedge clk_sys);
    close_out();
  end
endmodule
